// ==== rtl/rif_top.v ====
// Functional notes
// - Fh count high, Eh low, zero in program
// - Lock bit write-once, async reset only
// - Lock rejects writes to limit and to lockable ctrl bits
// - Clear bit 0 clears status, interrupt
// - Clear bit stays 0 until source drops
// - Writing 1 to clear bits does nothing
// - Bits 3..0 layout; clear bits reset 1
// - Mask 0 hides status until set
// - Raw condition always readable in condition register
// - Entropy ready after access; last word clears
// - Frequency failure sets its status
// - Any generator error sets hardware fault
// - Internal fault sets integrity status
// - Any integrity error raises severe event
// - Bus code mismatch sets error bit 3
// - Stored code mismatch sets bit 2
// - State copy mismatch sets bit 1
// - Integrity bits reset 0, upper reserved
// - Equal true/inverted copies set bit 0
// - Clear register: 1 clears (bit 1 needs a ctrl bit 17 write first), read errors
`timescale 1ns/100ps
`include "rif_defs.vh"
module rif_top (
  // Clock and resets
  input wire clk,
  input wire rst,
  input wire lockRstAsync,
  // APB slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire [3:0] pwdataCode,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  // Generator events
  input wire sampleValid,
  input wire [3:0] sampleNibble,
  input wire entropyGenerated,
  input wire entropyAccessBit,
  input wire lastEntropyRead,
  input wire freqCheckFailure,
  input wire genError,
  input wire [3:0] fsmState,
  input wire [3:0] fsmStateCopy,
  input wire guardSig,
  input wire guardSigInv,
  // Outputs
  output reg irq,
  output reg severeEvent,
  output reg [31:0] ctrlOut
);
  ////////////////////////////////////////////////////////////////////
  reg lock_ff;
  reg [3:0] iclr_ff;
  reg [3:0] ien_ff;
  reg [3:0] iflg_ff;
  reg [3:0] ierr_ff;
  reg [31:0] ctrl_ff;
  reg [31:0] limit_ff;
  reg [3:0] limitCode_ff;
  reg entReady_ff;
  reg fsmHold_ff;
  reg [3:0] nxt_iclr;
  reg [3:0] nxt_iflg;
  reg [3:0] nxt_ierr;
  reg [31:0] rdata;
  reg rerr;
  wire [15:0] nibF;
  wire [15:0] nibE;
  wire [3:0] busCode;
  wire [3:0] limitCode;
  wire [3:0] src;
  wire access;
  wire wrEn;
  wire rdEn;
  wire program_mode;
  ////////////////////////////////////////////////////////////////////
  assign access = psel && penable && !pready;
  assign wrEn = access && pwrite;
  assign rdEn = access && !pwrite;
  assign program_mode = ctrl_ff[`RIF_CTRL_PROGRAM_MODE];
  assign src[`RIF_IRQ_HWF] = genError;
  assign src[`RIF_IRQ_ENT] = entReady_ff;
  assign src[`RIF_IRQ_FRQ] = freqCheckFailure;
  assign src[`RIF_IRQ_INT] = |ierr_ff;

  rif_nibble_count uCount (
    .clk(clk),
    .rst(rst),
    .sampleValid(sampleValid),
    .sampleNibble(sampleNibble),
    .countClear(program_mode),
    .nibbleFCount_ff(nibF),
    .nibbleECount_ff(nibE)
  );

  rif_edc uBusEdc (
    .data(pwdata),
    .code(busCode)
  );

  rif_edc uLocEdc (
    .data(limit_ff),
    .code(limitCode)
  );

  ////////////////////////////////////////////////////////////////////
  // Lock bit, cleared only by asynchronous reset
  always @(posedge clk or posedge lockRstAsync) begin
    if (lockRstAsync) begin
      lock_ff <= 1'b0;
    end else if (wrEn && paddr == `RIF_OFF_LOCK && pwdata[`RIF_LOCK_BIT]) begin
      lock_ff <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Entropy ready flag
  always @(posedge clk) begin
    if (rst) begin
      entReady_ff <= 1'b0;
    end else if (entropyGenerated && entropyAccessBit && !program_mode) begin
      entReady_ff <= 1'b1;
    end else if (lastEntropyRead) begin
      entReady_ff <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Interrupt clear, status and integrity next values
  always @* begin
    nxt_iclr = iclr_ff;
    nxt_iflg = iflg_ff;
    nxt_ierr = ierr_ff;
    // Clear bits return to 1 once source drops
    nxt_iclr = iclr_ff | ~src;
    if (wrEn && paddr == `RIF_OFF_ICLR) begin
      nxt_iclr = nxt_iclr & pwdata[3:0];
      nxt_iflg = iflg_ff & pwdata[3:0];
    end
    // Clear write wins over set; set gated by clear and enable bits
    nxt_iflg = nxt_iflg | (src & nxt_iclr & ien_ff);
    // Masked status cannot be reported
    nxt_iflg = nxt_iflg & ien_ff;
    // Entropy ready status drops once the last word has been read
    if (!entReady_ff) begin
      nxt_iflg[`RIF_IRQ_ENT] = 1'b0;
    end
    if (wrEn && paddr == `RIF_OFF_ICLRERR) begin
      nxt_ierr = ierr_ff & ~pwdata[3:0];
    end
    if (fsmHold_ff) begin
      nxt_ierr[`RIF_ERR_FSM] = ierr_ff[`RIF_ERR_FSM];
    end
    if (wrEn && (pwdataCode != busCode)) begin
      nxt_ierr[`RIF_ERR_BUS] = 1'b1;
    end
    if (limitCode != limitCode_ff) begin
      nxt_ierr[`RIF_ERR_LOC] = 1'b1;
    end
    if (fsmState != fsmStateCopy) begin
      nxt_ierr[`RIF_ERR_FSM] = 1'b1;
    end
    if (guardSig == guardSigInv) begin
      nxt_ierr[`RIF_ERR_SIG] = 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Register writes
  always @(posedge clk) begin
    if (rst) begin
      iclr_ff <= `RIF_RST_ICLR;
      ien_ff <= `RIF_RST_IEN;
      iflg_ff <= 4'h0;
      ierr_ff <= 4'h0;
      ctrl_ff <= `RIF_RST_CTRL;
      limit_ff <= `RIF_RST_LIMIT;
      limitCode_ff <= 4'h0;
      fsmHold_ff <= 1'b1;
    end else begin
      iclr_ff <= nxt_iclr;
      iflg_ff <= nxt_iflg;
      ierr_ff <= nxt_ierr;
      if (wrEn && paddr == `RIF_OFF_IEN) begin
        ien_ff <= pwdata[3:0];
      end
      if (wrEn && paddr == `RIF_OFF_CTRL) begin
        if (lock_ff) begin
          ctrl_ff <= (ctrl_ff & `RIF_CTRL_LOCKMASK)
            | (pwdata & ~`RIF_CTRL_LOCKMASK);
        end else begin
          ctrl_ff <= pwdata;
        end
        // Error bit arms the state copy clear
        if (pwdata[`RIF_CTRL_ERRCLR]) begin
          fsmHold_ff <= 1'b0;
        end
      end else if (wrEn && paddr == `RIF_OFF_ICLRERR) begin
        fsmHold_ff <= 1'b1;
      end
      if (wrEn && paddr == `RIF_OFF_LIMIT && !lock_ff) begin
        limit_ff <= pwdata;
        limitCode_ff <= busCode;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Read mux
  always @* begin
    rdata = 32'h00000000;
    rerr = 1'b0;
    case (paddr)
      `RIF_OFF_NIBCNT: rdata = program_mode ? 32'h00000000 : {nibF, nibE};
      `RIF_OFF_LOCK: rdata[`RIF_LOCK_BIT] = lock_ff;
      `RIF_OFF_ICLR: rdata[3:0] = iclr_ff;
      `RIF_OFF_IEN: rdata[3:0] = ien_ff;
      `RIF_OFF_IFLG: rdata[3:0] = iflg_ff;
      `RIF_OFF_IERR: rdata[3:0] = ierr_ff;
      `RIF_OFF_ICLRERR: rerr = 1'b1;
      `RIF_OFF_CTRL: rdata = ctrl_ff;
      `RIF_OFF_LIMIT: rdata = limit_ff;
      `RIF_OFF_COND: rdata[3:0] = src;
      default: rerr = 1'b1;
    endcase
  end

  ////////////////////////////////////////////////////////////////////
  // APB answer and outputs
  always @(posedge clk) begin
    if (rst) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
      irq <= 1'b0;
      severeEvent <= 1'b0;
      ctrlOut <= `RIF_RST_CTRL;
    end else begin
      pready <= access;
      pslverr <= access && (pwrite ? (paddr > `RIF_OFF_COND) || (paddr[1:0] != 2'b00) : rerr);
      prdata <= rdEn ? rdata : 32'h00000000;
      irq <= |nxt_iflg;
      severeEvent <= |nxt_ierr;
      ctrlOut <= ctrl_ff;
    end
  end
endmodule // rif_top

// ==== rtl/rif_defs.vh ====
`ifndef RIF_DEFS_VH
`define RIF_DEFS_VH
// Register byte offsets
`define RIF_OFF_NIBCNT 12'h09c
`define RIF_OFF_LOCK 12'h0a0
`define RIF_OFF_ICLR 12'h0a4
`define RIF_OFF_IEN 12'h0a8
`define RIF_OFF_IFLG 12'h0ac
`define RIF_OFF_IERR 12'h0b0
`define RIF_OFF_ICLRERR 12'h0b4
`define RIF_OFF_CTRL 12'h0c0
`define RIF_OFF_LIMIT 12'h0c4
`define RIF_OFF_COND 12'h0c8
// Field positions
`define RIF_LOCK_BIT 1
`define RIF_IRQ_HWF 0
`define RIF_IRQ_ENT 1
`define RIF_IRQ_FRQ 2
`define RIF_IRQ_INT 3
`define RIF_ERR_SIG 0
`define RIF_ERR_FSM 1
`define RIF_ERR_LOC 2
`define RIF_ERR_BUS 3
`define RIF_CTRL_PROGRAM_MODE 16
`define RIF_CTRL_ERRCLR 17
// Lockable control bits: [1:0],[3:2],[6],[7],[14]
`define RIF_CTRL_LOCKMASK 32'h000040cf
// Reset values
`define RIF_RST_ICLR 4'hf
`define RIF_RST_IEN 4'hf
`define RIF_RST_CTRL 32'h00010000
`define RIF_RST_LIMIT 32'h00000000
`endif

// ==== rtl/rif_nibble_count.v ====
`timescale 1ns/100ps
`include "rif_defs.vh"
module rif_nibble_count (
  // Clock and reset
  input wire clk,
  input wire rst,
  // Sample nibbles
  input wire sampleValid,
  input wire [3:0] sampleNibble,
  input wire countClear,
  // Counts
  output reg [15:0] nibbleFCount_ff,
  output reg [15:0] nibbleECount_ff
);
  always @(posedge clk) begin
    if (rst || countClear) begin
      nibbleFCount_ff <= 16'h0000;
      nibbleECount_ff <= 16'h0000;
    end else if (sampleValid) begin
      if (sampleNibble == 4'hf) nibbleFCount_ff <= nibbleFCount_ff + 16'h0001;
      if (sampleNibble == 4'he) nibbleECount_ff <= nibbleECount_ff + 16'h0001;
    end
  end
endmodule // rif_nibble_count

// ==== rtl/rif_edc.v ====
`timescale 1ns/100ps
module rif_edc (
  // Data in
  input wire [31:0] data,
  // Code out
  output wire [3:0] code
);
  genvar i;
  generate
    for (i = 0; i < 4; i = i + 1) begin : gLane
      assign code[i] = ^data[8*i+7:8*i];
    end
  endgenerate
endmodule // rif_edc

// ==== tb/rif_chk.sv ====
`timescale 1ns/100ps
module rif_chk (
  // Clock, reset
  input wire clk,
  input wire rst,
  // Bus
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire [3:0] pwdataCode,
  input wire pready,
  input wire pslverr,
  // Faults, outputs
  input wire [3:0] fsmState,
  input wire [3:0] fsmStateCopy,
  input wire guardSig,
  input wire guardSigInv,
  input wire irq,
  input wire severeEvent
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  wire acc = psel && penable && !pready;
  wire clrWr = psel && penable && pwrite && paddr == 12'h0b4;
  wire [3:0] par = {^pwdata[31:24], ^pwdata[23:16], ^pwdata[15:8], ^pwdata[7:0]};
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("long pready");
  a_err_pair: assert property (pslverr |-> pready)
    else $error("lone pslverr");
  a_clr_read: assert property (acc && !pwrite && paddr == 12'h0b4 |=> pready && pslverr)
    else $error("clear read accepted");
  a_bus_code: assert property (acc && pwrite && pwdataCode != par |-> ##[1:3] severeEvent)
    else $error("bus code missed");
  a_sig_copy: assert property (guardSig == guardSigInv |-> ##[1:3] severeEvent)
    else $error("signal copy missed");
  a_fsm_copy: assert property (fsmState != fsmStateCopy |-> ##[1:3] severeEvent)
    else $error("state copy missed");
  a_sev_hold: assert property ($fell(severeEvent) |-> $past(clrWr) || $past(clrWr, 2))
    else $error("event dropped");
  a_rst_quiet: assert property ($fell(rst) |-> !irq && !severeEvent)
    else $error("not quiet at reset");
endmodule // rif_chk
bind rif_top rif_chk u_chk (.*);

// ==== tb/rif_tb_top.sv ====
`timescale 1ns/100ps
module rif_tb_top;
  reg clk = 0, rst = 1, lockRstAsync = 0, psel = 0, penable = 0, pwrite = 0, sampleValid = 0;
  reg entropyGenerated = 0, entropyAccessBit = 0, lastEntropyRead = 0, freqCheckFailure = 0;
  reg genError = 0, guardSig = 0, guardSigInv = 1, er;
  reg [3:0] pwdataCode = 0, sampleNibble = 0, fsmState = 0, fsmStateCopy = 0, flip = 0;
  reg [11:0] paddr = 0;
  reg [31:0] pwdata = 0, rd;
  wire [31:0] prdata, ctrlOut;
  wire pready, pslverr, irq, severeEvent;
  integer bad_count = 0, n_tests = 0, i;
  always #12.5 clk = ~clk;
  rif_top u_dut (.*);
  ////////////////////////////////
  task chk(input string nm, input [31:0] e, input [31:0] g);
    begin
      n_tests = n_tests + 1;
      if (g !== e) begin
        bad_count = bad_count + 1;
        $display("MISMATCH %s exp %h got %h", nm, e, g);
      end
    end
  endtask
  task cyc(input integer n);
    repeat (n) @(posedge clk);
  endtask
  task bus(input w, input [11:0] a, input [31:0] d);
    begin
      @(posedge clk);
      psel <= 1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      pwdataCode <= {^d[31:24], ^d[23:16], ^d[15:8], ^d[7:0]} ^ flip;
      @(posedge clk);
      penable <= 1;
      @(posedge clk);
      while (pready !== 1'b1) begin
        @(posedge clk);
      end
      rd = prdata;
      er = pslverr;
      psel <= 0;
      penable <= 0;
    end
  endtask
  task rdc(input string nm, input [11:0] a, input [31:0] m, input [31:0] e);
    begin
      bus(0, a, 32'h0);
      chk(nm, e, rd & m);
    end
  endtask
  ////////////////////////////////
  task s_cnt;
    begin
      chk("ctrl", 32'h00010000, ctrlOut);
      rdc("iclr", 12'h0a4, 32'hf, 32'hf);
      rdc("ierr", 12'h0b0, 32'hffffffff, 32'h0);
      bus(1, 12'h0c0, 32'h0);
      for (i = 0; i < 6; i = i + 1) begin
        @(posedge clk);
        sampleValid <= 1;
        sampleNibble <= (i < 3) ? 4'hf : (i < 5) ? 4'he : 4'h5;
      end
      @(posedge clk);
      sampleValid <= 0;
      rdc("cnt", 12'h09c, 32'hffffffff, 32'h00030002);
      bus(1, 12'h0c0, 32'h00010000);
      rdc("cnt", 12'h09c, 32'hffffffff, 32'h0);
    end
  endtask
  task s_irq;
    begin
      genError <= 1;
      cyc(3);
      rdc("flg", 12'h0ac, 32'hf, 32'h1);
      chk("irq", 32'h1, irq);
      bus(1, 12'h0a4, 32'he);
      rdc("flg", 12'h0ac, 32'hf, 32'h0);
      chk("irq", 32'h0, irq);
      rdc("iclr", 12'h0a4, 32'hf, 32'he);
      rdc("raw", 12'h0c8, 32'h1, 32'h1);
      genError <= 0;
      cyc(3);
      rdc("iclr", 12'h0a4, 32'hf, 32'hf);
      bus(1, 12'h0a8, 32'he);
      genError <= 1;
      cyc(3);
      rdc("flg", 12'h0ac, 32'hf, 32'h0);
      bus(1, 12'h0a8, 32'hf);
      rdc("flg", 12'h0ac, 32'hf, 32'h1);
      genError <= 0;
      bus(1, 12'h0a4, 32'he);
      cyc(3);
      bus(1, 12'h0a4, 32'hf);
      rdc("flg", 12'h0ac, 32'hf, 32'h0);
      chk("irq", 32'h0, irq);
    end
  endtask
  task s_ent;
    begin
      bus(1, 12'h0c0, 32'h0);
      freqCheckFailure <= 1;
      entropyAccessBit <= 1;
      entropyGenerated <= 1;
      cyc(1);
      entropyGenerated <= 0;
      cyc(2);
      rdc("flg", 12'h0ac, 32'hf, 32'h6);
      lastEntropyRead <= 1;
      freqCheckFailure <= 0;
      cyc(1);
      lastEntropyRead <= 0;
      cyc(2);
      rdc("flg", 12'h0ac, 32'h2, 32'h0);
    end
  endtask
  task s_err;
    begin
      flip <= 4'h1;
      bus(1, 12'h0a8, 32'hf);
      flip <= 4'h0;
      cyc(3);
      rdc("ierr", 12'h0b0, 32'hffffffff, 32'h8);
      rdc("flg", 12'h0ac, 32'h8, 32'h8);
      chk("sev", 32'h1, severeEvent);
      bus(1, 12'h0b4, 32'h8);
      rdc("ierr", 12'h0b0, 32'hffffffff, 32'h0);
      chk("sev", 32'h0, severeEvent);
      bus(0, 12'h0b4, 32'h0);
      chk("slverr", 32'h1, er);
      guardSig <= 1;
      fsmState <= 4'h3;
      cyc(3);
      guardSig <= 0;
      fsmState <= 4'h0;
      bus(1, 12'h0b4, 32'h3);
      rdc("ierr", 12'h0b0, 32'hffffffff, 32'h2);
      bus(1, 12'h0c0, 32'h00020000);
      bus(1, 12'h0b4, 32'h2);
      rdc("ierr", 12'h0b0, 32'hffffffff, 32'h0);
    end
  endtask
  task s_lock;
    begin
      bus(1, 12'h0a0, 32'h2);
      bus(1, 12'h0a0, 32'h0);
      rdc("lock", 12'h0a0, 32'h2, 32'h2);
      bus(1, 12'h0c0, 32'h408f);
      cyc(1);
      chk("ctrl", 32'h0, ctrlOut & 32'h408f);
      lockRstAsync <= 1;
      cyc(1);
      lockRstAsync <= 0;
      rdc("lock", 12'h0a0, 32'h2, 32'h0);
      bus(1, 12'h0c0, 32'h408f);
      cyc(1);
      chk("ctrl", 32'h408f, ctrlOut & 32'h408f);
    end
  endtask
  ////////////////////////////////
  task results;
    begin
      $display("tests %0d mismatches %0d", n_tests, bad_count);
      if (bad_count == 0 && n_tests > 0)
        $display("[ PASS ]");
      else
        $display("[ FAIL ]");
      $finish;
    end
  endtask
  initial begin
    repeat (20) @(posedge clk);
    rst <= 0;
    s_cnt;
    s_irq;
    s_ent;
    s_err;
    s_lock;
    results;
  end
  initial begin
    repeat (3000) @(posedge clk);
    bad_count = bad_count + 1;
    results;
  end
endmodule // rif_tb_top
